// ===== hdl/psc_top.sv
// top: apb register file, status, interrupts and clock core
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
module psc_top
  import psc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clock_mode_strap,
  input wire logic pll_lock,
  input wire logic loss_clock_flag,
  input wire logic stop_req,
  input wire logic wake_req,
  output logic sys_clk_en,
  output logic clock_output_pin,
  output logic pll_enable,
  output logic osc_enable,
  output logic loc_reset,
  output logic self_clocked,
  output logic irq
);
  psc_ctrl_if ctl ();

  logic [15:0] ctrl_r;
  logic clock_mode_r;
  logic locks_r;
  logic lock_d_r;
  logic [2:0] irq_stat_r, irq_mask_r;
  logic [31:0] prdata_r;
  logic wr_en, rd_en, hit_ctrl, hit_stat, hit_istat, hit_imask, addr_ok;
  logic [7:0] stat_word;
  logic [2:0] irq_evt;
  logic wake_event;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign hit_ctrl = paddr == PSC_OFF_CTRL;
  assign hit_stat = paddr == PSC_OFF_STAT;
  assign hit_istat = paddr == PSC_OFF_IRQ_STAT;
  assign hit_imask = paddr == PSC_OFF_IRQ_MASK;
  assign addr_ok = hit_ctrl || hit_stat || hit_istat || hit_imask;
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_r <= PSC_CTRL_RESET;
    end else if (wr_en && hit_ctrl) begin
      ctrl_r <= pwdata[15:0] & PSC_CTRL_WMASK;
    end
  end
  assign ctl.loc_rst_en = ctrl_r[PSC_B_LOC_RST_EN];
  assign ctl.reduced_freq_divider = ctrl_r[PSC_B_RFD_HI:PSC_B_RFD_LO];
  assign ctl.loc_det_en = ctrl_r[PSC_B_LOC_DET_EN];
  assign ctl.clk_dis = ctrl_r[PSC_B_CLK_DIS];
  assign ctl.fast_wake = ctrl_r[PSC_B_FAST_WAKE];
  assign ctl.stop_mode_power_sel = ctrl_r[PSC_B_STOP_MODE_POWER_SEL_HI:PSC_B_STOP_MODE_POWER_SEL_LO];

  // ----------------------------------------------------------------
  // status
  // ----------------------------------------------------------------
  // strap and sticky lock are taken on every clock edge while reset is held
  always_ff @(posedge sys_clk) begin
    lock_d_r <= sys_rst ? 1'b0 : pll_lock;
    if (sys_rst) begin
      clock_mode_r <= clock_mode_strap;
    end
    // sticky lock; lock threshold lives in the analog detector
    if (sys_rst) begin
      locks_r <= clock_mode_strap;
    end else if (!pll_lock) begin
      locks_r <= 1'b0;
    end
  end
  always_comb begin
    stat_word = 8'h00;
    stat_word[PSC_S_MODE] = clock_mode_r;
    stat_word[PSC_S_LOCKS] = locks_r && clock_mode_r;
    stat_word[PSC_S_LOCK] = pll_lock && clock_mode_r;
    stat_word[PSC_S_LOC] = loss_clock_flag && clock_mode_r && ctl.loc_det_en;
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign irq_evt[PSC_I_LOSS_LOCK] = lock_d_r && !pll_lock && clock_mode_r;
  assign irq_evt[PSC_I_LOSS_CLK] = stat_word[PSC_S_LOC];
  assign irq_evt[PSC_I_WAKE] = wake_event;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_stat_r <= PSC_IRQ_RESET;
      irq_mask_r <= PSC_IRQ_RESET;
    end else begin
      // set wins over write-one-to-clear
      irq_stat_r <= (irq_stat_r & ~((wr_en && hit_istat) ? pwdata[2:0] : 3'h0)) | irq_evt;
      if (wr_en && hit_imask) begin
        irq_mask_r <= pwdata[2:0];
      end
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata_r <= hit_ctrl ? {16'h0000, ctrl_r} :
                  hit_stat ? {24'h000000, stat_word} :
                  hit_istat ? {29'h0, irq_stat_r} :
                  hit_imask ? {29'h0, irq_mask_r} : 32'h0000_0000;
    end
  end
  assign prdata = prdata_r;

  // ----------------------------------------------------------------
  // clock core
  // ----------------------------------------------------------------
  psc_clk_core u_core (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .ctl(ctl.core),
    .pll_mode(clock_mode_r),
    .pll_lock(pll_lock),
    .loss_clock_flag(loss_clock_flag),
    .stop_req(stop_req),
    .wake_req(wake_req),
    .sys_clk_en(sys_clk_en),
    .clock_output_pin(clock_output_pin),
    .pll_enable(pll_enable),
    .osc_enable(osc_enable),
    .loc_reset(loc_reset),
    .wake_event(wake_event),
    .self_clocked(self_clocked)
  );
endmodule : psc_top

// ===== hdl/psc_pkg.sv
// package: register map, field positions and constants of the synthesizer control block
package psc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PSC_OFF_CTRL = 8'h00;
  localparam logic [7:0] PSC_OFF_STAT = 8'h04;
  localparam logic [7:0] PSC_OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] PSC_OFF_IRQ_MASK = 8'h0C;
  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int PSC_B_LOC_RST_EN = 11;
  localparam int PSC_B_RFD_HI = 10;
  localparam int PSC_B_RFD_LO = 8;
  localparam int PSC_B_LOC_DET_EN = 7;
  localparam int PSC_B_CLK_DIS = 6;
  localparam int PSC_B_FAST_WAKE = 5;
  localparam int PSC_B_STOP_MODE_POWER_SEL_HI = 3;
  localparam int PSC_B_STOP_MODE_POWER_SEL_LO = 2;
  localparam logic [15:0] PSC_CTRL_WMASK = 16'h0FEC;
  localparam logic [15:0] PSC_CTRL_RESET = 16'h0000;
  // ----------------------------------------------------------------
  // status field positions
  // ----------------------------------------------------------------
  localparam int PSC_S_MODE = 7;
  localparam int PSC_S_LOCKS = 4;
  localparam int PSC_S_LOCK = 3;
  localparam int PSC_S_LOC = 2;
  // ----------------------------------------------------------------
  // interrupt bits
  // ----------------------------------------------------------------
  localparam int PSC_I_LOSS_LOCK = 0;
  localparam int PSC_I_LOSS_CLK = 1;
  localparam int PSC_I_WAKE = 2;
  localparam logic [2:0] PSC_IRQ_RESET = 3'h0;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int PSC_CLK_MHZ = 250;
  localparam int PSC_RST_PULSE_NS = 16;
  localparam int PSC_RST_PULSE_CYC = (PSC_RST_PULSE_NS * PSC_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] PSC_RST_CNT_MAX = 4'(PSC_RST_PULSE_CYC);

  typedef enum logic [1:0] {
    PSC_RUN = 2'b00,
    PSC_STOP = 2'b01,
    PSC_WAKE = 2'b11
  } psc_state_e;

  // stop-mode table: {pll, osc, clock_output_pin} enables per code
  function automatic logic [2:0] psc_stop_enables(input logic [1:0] code);
    case (code)
      2'b00: psc_stop_enables = 3'b111;
      2'b01: psc_stop_enables = 3'b110;
      2'b10: psc_stop_enables = 3'b010;
      default: psc_stop_enables = 3'b000;
    endcase
  endfunction : psc_stop_enables
endpackage : psc_pkg

// ===== hdl/psc_ctrl_if.sv
// interface: control fields passed from register file to clock core
`timescale 1ns/1ps
interface psc_ctrl_if;
  logic loc_rst_en;
  logic loc_det_en;
  logic [2:0] reduced_freq_divider;
  logic clk_dis;
  logic fast_wake;
  logic [1:0] stop_mode_power_sel;
  modport regs (output loc_rst_en, loc_det_en, reduced_freq_divider, clk_dis, fast_wake, stop_mode_power_sel);
  modport core (input loc_rst_en, loc_det_en, reduced_freq_divider, clk_dis, fast_wake, stop_mode_power_sel);
endinterface : psc_ctrl_if

// ===== hdl/psc_clk_core.sv
// clock core: divider enable, stop-mode gating, wakeup and loss-of-clock reset
`timescale 1ns/1ps
module psc_clk_core
  import psc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  psc_ctrl_if.core ctl,
  input wire logic pll_mode,
  input wire logic pll_lock,
  input wire logic loss_clock_flag,
  input wire logic stop_req,
  input wire logic wake_req,
  output logic sys_clk_en,
  output logic clock_output_pin,
  output logic pll_enable,
  output logic osc_enable,
  output logic loc_reset,
  output logic wake_event,
  output logic self_clocked
);
  psc_state_e state_r, state_nxt;
  logic [5:0] div_cnt_r;
  logic [2:0] rfd_r;
  logic [3:0] rst_cnt_r;
  logic div_tick;
  logic loc_active;
  logic [2:0] stop_en;
  logic wake_done;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  // divisor selector
  assign div_tick = (div_cnt_r & ((6'h01 << rfd_r) - 6'h01)) == 6'h00;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      div_cnt_r <= 6'h00;
      rfd_r <= 3'h0;
    end else begin
      // change at period boundary, no glitch
      // restart the count so the first new period is a whole one
      if (div_tick) begin
        rfd_r <= ctl.reduced_freq_divider;
        div_cnt_r <= 6'h01;
      end else begin
        div_cnt_r <= div_cnt_r + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // stop and wakeup
  // ----------------------------------------------------------------
  // stop code table
  assign stop_en = psc_stop_enables(ctl.stop_mode_power_sel);
  assign wake_done = !pll_mode || ctl.fast_wake || pll_lock || loss_clock_flag;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PSC_RUN: if (stop_req) state_nxt = PSC_STOP;
      PSC_STOP: if (wake_req) state_nxt = PSC_WAKE;
      PSC_WAKE: if (wake_done) state_nxt = PSC_RUN;
      default: state_nxt = PSC_RUN;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= PSC_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end
  assign wake_event = (state_r == PSC_WAKE) && wake_done;
  assign self_clocked = pll_mode && !ctl.fast_wake && loss_clock_flag && (state_r != PSC_RUN);
  // system clocks always off in stop
  assign sys_clk_en = (state_r == PSC_RUN) && div_tick;
  assign pll_enable = (state_r != PSC_STOP) || stop_en[2];
  assign osc_enable = (state_r != PSC_STOP) || stop_en[1];
  // pin follows the divider, so stop code 00 keeps it running
  assign clock_output_pin = !ctl.clk_dis && div_tick && ((state_r != PSC_STOP) || stop_en[0]);

  // ----------------------------------------------------------------
  // loss-of-clock reset
  // ----------------------------------------------------------------
  // detect gating
  assign loc_active = pll_mode && ctl.loc_det_en && loss_clock_flag;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rst_cnt_r <= 4'h0;
    end else if (loc_active && ctl.loc_rst_en) begin
      rst_cnt_r <= PSC_RST_CNT_MAX;
    end else if (rst_cnt_r != 4'h0) begin
      rst_cnt_r <= rst_cnt_r - 4'h1;
    end
  end
  assign loc_reset = (loc_active && ctl.loc_rst_en) || (rst_cnt_r != 4'h0);
endmodule : psc_clk_core

// ===== tb/psc_checker.sv
// checker: port-level properties of the synthesizer control block
`timescale 1ns/1ps
module psc_checker
  import psc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic clock_mode_strap,
  input wire logic pll_lock,
  input wire logic loss_clock_flag,
  input wire logic stop_req,
  input wire logic wake_req,
  input wire logic sys_clk_en,
  input wire logic clock_output_pin,
  input wire logic pll_enable,
  input wire logic osc_enable,
  input wire logic loc_reset,
  input wire logic self_clocked
);
  // ----------------------------------------------------------------
  // shadow of control register, mode and stop state
  // ----------------------------------------------------------------
  logic [15:0] c_r;
  logic mode_r;
  psc_state_e st_r;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      c_r <= PSC_CTRL_RESET;
      mode_r <= clock_mode_strap;
      st_r <= PSC_RUN;
    end else begin
      if (psel && penable && pwrite && paddr == PSC_OFF_CTRL) c_r <= pwdata[15:0] & PSC_CTRL_WMASK;
      if (st_r == PSC_RUN && stop_req) st_r <= PSC_STOP;
      if (st_r == PSC_STOP && wake_req) st_r <= PSC_WAKE;
      if (st_r == PSC_WAKE && (!mode_r || c_r[5] || pll_lock || loss_clock_flag)) st_r <= PSC_RUN;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_LOC_RST: assert property (mode_r && c_r[7] && c_r[11] && loss_clock_flag |-> loc_reset)
    else $error("loss of clock did not raise reset");
  // stretch of 4 cycles has run out after 6
  AST_DET_OFF: assert property ((!c_r[7]) [*6] |-> !loc_reset)
    else $error("reset while detect disabled");
  AST_EXT_MODE: assert property (!mode_r |-> !loc_reset)
    else $error("reset in external clock mode");
  AST_CLK_DIS: assert property (c_r[6] |-> !clock_output_pin)
    else $error("clock output not held low");
  AST_CTRL_RD: assert property (psel && penable && !pwrite && paddr == PSC_OFF_CTRL
    |-> prdata == {16'h0000, c_r})
    else $error("control read mismatch");
  AST_STOP: assert property (st_r == PSC_STOP |-> !sys_clk_en && pll_enable == !c_r[3]
    && osc_enable == (c_r[3:2] != 2'b11) && (c_r[3:2] == 2'b00 || !clock_output_pin))
    else $error("stop gating wrong");
  AST_WAKE_WAIT: assert property (st_r == PSC_WAKE && mode_r && !c_r[5]
    && !pll_lock && !loss_clock_flag |-> !sys_clk_en)
    else $error("clocks ran before lock");
  AST_FAST: assert property (st_r == PSC_WAKE && (c_r[5] || !mode_r)
    && c_r[10:8] == 3'h0 |=> sys_clk_en)
    else $error("clocks not resumed on wakeup");
  AST_SELF: assert property (mode_r && !c_r[5] && loss_clock_flag && st_r != PSC_RUN |-> self_clocked)
    else $error("self clocked mode missing");
  AST_DIV: assert property ((st_r == PSC_RUN && c_r[10:8] == 3'h1 && sys_clk_en)
    ##1 (st_r == PSC_RUN && c_r[10:8] == 3'h1) |-> !sys_clk_en)
    else $error("divide by two pulsed twice");
  cover property (st_r == PSC_WAKE);
  cover property (loc_reset);
  cover property (st_r == PSC_STOP && c_r[3:2] == 2'b11);
endmodule : psc_checker

bind psc_top psc_checker chk_u (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr,
  .clock_mode_strap, .pll_lock, .loss_clock_flag, .stop_req, .wake_req, .sys_clk_en, .clock_output_pin,
  .pll_enable, .osc_enable, .loc_reset, .self_clocked);

// ===== tb/psc_tb_top.sv
// testbench: register, divider, stop, wakeup and loss-of-clock tests
`timescale 1ns/1ps
module psc_tb_top
  import psc_pkg::*;
;
  logic sys_clk, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, clock_mode_strap = 1;
  logic pll_lock = 1, loss_clock_flag = 0, stop_req = 0, wake_req = 0, err;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, sys_clk_en, clock_output_pin, pll_enable, osc_enable, loc_reset, self_clocked, irq;
  int n_errors = 0, checks = 0, cyc = 0, cnt;
  psc_top dut_u (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .clock_mode_strap, .pll_lock, .loss_clock_flag, .stop_req, .wake_req, .sys_clk_en, .clock_output_pin,
    .pll_enable, .osc_enable, .loc_reset, .self_clocked, .irq);
  initial begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task report_and_stop;
    $display("mismatches %0d comparisons %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // stop when s is set, wake otherwise
  task pulse(input logic s);
    @(posedge sys_clk);
    stop_req <= s;
    wake_req <= !s;
    @(posedge sys_clk);
    stop_req <= 1'b0;
    wake_req <= 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : pulse
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    xfer(0, PSC_OFF_CTRL, 0);
    chk(rd, 32'h0000_0000);
    xfer(1, PSC_OFF_CTRL, 32'hFFFF_FFFF);
    xfer(0, PSC_OFF_CTRL, 0);
    chk(rd, 32'h0000_0FEC);
    xfer(0, PSC_OFF_STAT, 0);
    chk(rd[PSC_S_MODE], 1'b1);
    xfer(0, 8'h10, 0);
    chk({31'h0, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    // unmapped write must leave the control word alone
    xfer(1, 8'h10, 32'h0000_0000);
    xfer(0, PSC_OFF_CTRL, 0);
    chk(rd, 32'h0000_0FEC);
    // slowest divisor is 64 cycles, so each settle covers the old period
    for (int r = 0; r < 4; r++) begin
      xfer(1, PSC_OFF_CTRL, 32'(r) << 8);
      repeat (72) @(negedge sys_clk);
      cnt = 0;
      repeat (32) @(negedge sys_clk) cnt += sys_clk_en;
      chk(cnt, 32 >> r);
    end
    xfer(1, PSC_OFF_CTRL, 32'h0000_0040);
    repeat (8) @(negedge sys_clk) chk(clock_output_pin, 1'b0);
    xfer(1, PSC_OFF_CTRL, 32'h0000_0000);
    @(negedge sys_clk) chk(clock_output_pin, 1'b1);
    xfer(1, PSC_OFF_CTRL, 32'h0000_0880);
    loss_clock_flag <= 1'b1;
    repeat (2) @(negedge sys_clk);
    chk({loc_reset, irq}, 2'b10);
    xfer(1, PSC_OFF_IRQ_MASK, 32'h2);
    loss_clock_flag <= 1'b0;
    @(negedge sys_clk) chk(irq, 1'b1);
    xfer(1, PSC_OFF_IRQ_STAT, 32'h2);
    @(negedge sys_clk) chk(irq, 1'b0);
    xfer(1, PSC_OFF_CTRL, 32'h0000_0800);
    loss_clock_flag <= 1'b1;
    repeat (8) @(negedge sys_clk) chk(loc_reset, 1'b0);
    xfer(1, PSC_OFF_CTRL, 32'h0000_0080);
    repeat (2) @(negedge sys_clk) chk(loc_reset, 1'b0);
    @(posedge sys_clk) loss_clock_flag <= 1'b0;
    // reset enable stays clear across every stop
    for (int m = 0; m < 4; m++) begin
      xfer(1, PSC_OFF_CTRL, 32'(m) << 2);
      pulse(1);
      chk({sys_clk_en, pll_enable, osc_enable, clock_output_pin}, {1'b0, m < 2, m != 3, m == 0});
      pulse(0);
      chk(sys_clk_en, 1'b1);
    end
    xfer(1, PSC_OFF_CTRL, 0);
    loss_clock_flag <= 1'b1;
    pulse(1);
    chk(self_clocked, 1'b1);
    pulse(0);
    @(posedge sys_clk) loss_clock_flag <= 1'b0;
    pll_lock <= 1'b0;
    pulse(1);
    pulse(0);
    chk(sys_clk_en, 1'b0);
    @(posedge sys_clk) pll_lock <= 1'b1;
    @(negedge sys_clk) chk(sys_clk_en, 1'b0);
    repeat (2) @(negedge sys_clk) chk(sys_clk_en, 1'b1);
    xfer(1, PSC_OFF_CTRL, 32'h0000_0020);
    pll_lock <= 1'b0;
    pulse(1);
    pulse(0);
    chk(sys_clk_en, 1'b1);
    // loss of lock, loss of clock and wake events all left sticky
    xfer(0, PSC_OFF_IRQ_STAT, 0);
    chk(rd, 32'h0000_0007);
    xfer(1, PSC_OFF_IRQ_STAT, 32'h0000_0007);
    xfer(0, PSC_OFF_IRQ_STAT, 0);
    chk(rd, 32'h0000_0000);
    @(posedge sys_clk) sys_rst <= 1'b1;
    clock_mode_strap <= 1'b0;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    xfer(0, PSC_OFF_CTRL, 0);
    chk(rd, 32'h0000_0000);
    xfer(0, PSC_OFF_STAT, 0);
    chk(rd[PSC_S_MODE], 1'b0);
    xfer(1, PSC_OFF_CTRL, 32'h0000_0880);
    pulse(1);
    pulse(0);
    chk(sys_clk_en, 1'b1);
    @(posedge sys_clk) loss_clock_flag <= 1'b1;
    repeat (3) @(negedge sys_clk) chk(loc_reset, 1'b0);
    report_and_stop();
  end
endmodule : psc_tb_top
